// ---- logic/rswc_ctrl.sv ----
// Reset, start-up delay, watchdog and suspend sequencer with the
// processor status and control register.
// Assumes the core gives one-cycle instruction strobes on clk, and that
// porIn and oscStable come from analog pins outside this clock domain.
`timescale 1ns/100ps
`include "rswc_map.svh"

module rswc_ctrl #(
    parameter int NDOWN      = 4,
    parameter int SEMI1_US   = `RSWC_T_SEMI1_US,
    parameter int SEMI95_US  = `RSWC_T_SEMI95_US,
    parameter int WDR_US     = `RSWC_T_WDR_US,
    parameter int WATCH_US   = `RSWC_T_WATCH_US,
    parameter int RESUME_US  = `RSWC_T_RESUME_US,
    parameter int SEMI1_CYC  = SEMI1_US * `RSWC_CLK_KHZ / 1000,
    parameter int SEMI95_CYC = SEMI95_US * `RSWC_CLK_KHZ / 1000,
    parameter int WDR_CYC    = WDR_US * `RSWC_CLK_KHZ / 1000,
    parameter int WATCH_CYC  = (WATCH_US * `RSWC_CLK_KHZ + 999) / 1000,
    parameter int RESUME_CYC = RESUME_US * `RSWC_CLK_KHZ / 1000
) (
    // Clock and control
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 clkEn,
    // Analog pins
    input  wire logic                 porIn,
    input  wire logic                 oscStable,
    // USB and GPIO events
    input  wire logic                 busResetIn,
    input  wire logic                 upActivity,
    input  wire logic [NDOWN-1:0]     downActivity,
    input  wire logic                 gpioWake,
    input  wire logic                 busResetIntEn,
    input  wire logic                 irqPendingIn,
    // Core instruction strobes
    input  wire rswc_pkg::rswc_cpu_s  cpu,
    // I/O register port
    input  wire logic [7:0]           ioAddr,
    input  wire logic [7:0]           ioWrData,
    input  wire logic                 ioWr,
    input  wire logic                 ioRd,
    output logic      [7:0]           ioRdData,
    // Core and system control
    output logic                      cpuReset,
    output logic                      cpuRun,
    output logic                      fetchZero,
    output logic                      usbAddrClear,
    output logic                      irqHold,
    output logic                      busResetIrqReq,
    output rswc_pkg::rswc_pwr_s       pwr
);

    localparam int CW = 21;
    localparam int WW = 18;

    // =====================================================================
    // Pin synchronisers
    logic porS1Q;
    logic porS2Q;
    logic oscS1Q;
    logic oscS2Q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            porS1Q <= 1'b1;
            porS2Q <= 1'b1;
            oscS1Q <= 1'b0;
            oscS2Q <= 1'b0;
        end else if (clkEn) begin
            porS1Q <= porIn;
            porS2Q <= porS1Q;
            oscS1Q <= oscStable;
            oscS2Q <= oscS1Q;
        end
    end

    // =====================================================================
    // Sequencer, watchdog and status register
    rswc_pkg::rswc_state_e stateQ, stateD;
    rswc_pkg::rswc_ctl_s   ctlQ, ctlD;
    logic [CW-1:0]         cntQ, cntD;
    logic [WW-1:0]         wdQ, wdD;
    logic                  holdQ, holdD;
    logic                  fetchQ, fetchD;
    logic [7:0]            rdQ, rdD;
    logic                  pscWr;
    logic                  wdWr;
    logic                  wdRun;
    logic                  wdRoll;
    logic                  anyAct;
    logic                  inReset;
    logic [7:0]            pscImg;

    localparam logic [7:0] RSTV = `RSWC_PSC_RST;
    localparam logic [7:0] WDRV = `RSWC_PSC_WDR;

    function automatic logic hit(input logic [CW-1:0] c, input int n);
        hit = (c == CW'(n - 1));
    endfunction

    assign pscWr  = ioWr && (ioAddr == `RSWC_A_PSC);
    assign wdWr   = ioWr && (ioAddr == `RSWC_A_WD_RESTART);
    assign anyAct = upActivity || (|downActivity);
    // Watchdog stops while suspended and during its own reset
    assign wdRun  = (stateQ == rswc_pkg::ST_SEMI1) || (stateQ == rswc_pkg::ST_SEMI95)
                 || (stateQ == rswc_pkg::ST_RUN) || (stateQ == rswc_pkg::ST_HALT);
    assign wdRoll = wdRun && (wdQ == WW'(WATCH_CYC - 1));

    always_comb begin
        pscImg = {irqPendingIn, ctlQ.watchdog_reset_event, ctlQ.busRst, ctlQ.por,
                  (stateQ == rswc_pkg::ST_SUSP), ctlQ.gie, ctlQ.rsvd, ctlQ.run};
    end

    always_comb begin
        stateD = stateQ;
        ctlD   = ctlQ;
        cntD   = cntQ + CW'(1);
        wdD    = wdQ;
        holdD  = holdQ;
        rdD    = 8'h00;
        if (ioRd && ioAddr == `RSWC_A_PSC) begin
            rdD = pscImg;
        end
        if (wdWr) begin
            wdD = '0;
        end else if (wdRun) begin
            wdD = wdQ + WW'(1);
        end
        if (porS2Q) begin
            stateD = rswc_pkg::ST_POR;
            ctlD   = '{RSTV[6], RSTV[5], RSTV[4], RSTV[2], RSTV[1], RSTV[0]};
            cntD   = '0;
            wdD    = '0;
            holdD  = 1'b0;
        end else if (wdRoll) begin
            stateD = rswc_pkg::ST_WDRST;
            ctlD   = '{WDRV[6], WDRV[5], ctlQ.por, WDRV[2], WDRV[1], WDRV[0]};
            cntD   = '0;
            wdD    = '0;
            holdD  = 1'b0;
        end else begin
            unique case (stateQ)
                rswc_pkg::ST_POR: begin
                    cntD = '0;
                    if (oscS2Q) begin
                        stateD = rswc_pkg::ST_SEMI1;
                    end
                end
                rswc_pkg::ST_SEMI1: begin
                    if (hit(cntQ, SEMI1_CYC)) begin
                        stateD = rswc_pkg::ST_SEMI95;
                        cntD   = '0;
                    end
                end
                rswc_pkg::ST_SEMI95: begin
                    if (busResetIn || hit(cntQ, SEMI95_CYC)) begin
                        stateD = rswc_pkg::ST_RUN;
                    end
                end
                rswc_pkg::ST_WDRST: begin
                    if (hit(cntQ, WDR_CYC)) begin
                        stateD = rswc_pkg::ST_RUN;
                    end
                end
                rswc_pkg::ST_RUN: begin
                    if (cpu.done) begin
                        holdD = 1'b0;
                    end
                    if (cpu.ei || cpu.interrupt_return_instruction) begin
                        ctlD.gie = 1'b1;
                    end else if (cpu.di || cpu.ack) begin
                        ctlD.gie = 1'b0;
                    end
                    if (cpu.halt) begin
                        stateD = rswc_pkg::ST_HALT;
                        ctlD   = '0;
                    end else if (pscWr) begin
                        ctlD.watchdog_reset_event    = ioWrData[`RSWC_B_WDR];
                        ctlD.busRst = ioWrData[`RSWC_B_BUSRST];
                        ctlD.por    = ioWrData[`RSWC_B_POR];
                        ctlD.rsvd   = ioWrData[`RSWC_B_RSVD];
                        ctlD.run    = ioWrData[`RSWC_B_RUN];
                        if (ioWrData[`RSWC_B_SUSP] && !anyAct) begin
                            stateD = rswc_pkg::ST_SUSP;
                        end
                    end
                end
                rswc_pkg::ST_HALT: begin
                    cntD = '0;
                end
                rswc_pkg::ST_SUSP: begin
                    cntD = '0;
                    if (gpioWake || anyAct) begin
                        stateD = ctlQ.run ? rswc_pkg::ST_WAKE : rswc_pkg::ST_HALT;
                    end
                end
                rswc_pkg::ST_WAKE: begin
                    if (!oscS2Q) begin
                        cntD = '0;
                    end else if (hit(cntQ, RESUME_CYC)) begin
                        stateD = rswc_pkg::ST_RUN;
                        holdD  = 1'b1;
                    end
                end
            endcase
            if (busResetIn) begin
                ctlD.busRst = 1'b1;
            end
        end
        if (stateD != stateQ) begin
            cntD = '0;
        end
    end

    assign inReset = (stateQ == rswc_pkg::ST_POR) || (stateQ == rswc_pkg::ST_SEMI1)
                  || (stateQ == rswc_pkg::ST_SEMI95) || (stateQ == rswc_pkg::ST_WDRST);
    assign fetchD  = inReset && (stateD == rswc_pkg::ST_RUN);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stateQ <= rswc_pkg::ST_POR;
            ctlQ   <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
            cntQ   <= '0;
            wdQ    <= '0;
            holdQ  <= 1'b0;
            fetchQ <= 1'b0;
            rdQ    <= 8'h00;
        end else if (clkEn) begin
            stateQ <= stateD;
            ctlQ   <= ctlD;
            cntQ   <= cntD;
            wdQ    <= wdD;
            holdQ  <= holdD;
            fetchQ <= fetchD;
            rdQ    <= rdD;
        end
    end

    // =====================================================================
    // Outputs
    assign ioRdData       = rdQ;
    assign fetchZero      = fetchQ;
    assign irqHold        = holdQ;
    assign cpuReset       = inReset;
    assign cpuRun         = (stateQ == rswc_pkg::ST_RUN) && ctlQ.run;
    assign usbAddrClear   = (stateQ == rswc_pkg::ST_POR) || (stateQ == rswc_pkg::ST_WDRST);
    assign busResetIrqReq = ctlQ.busRst && busResetIntEn && ctlQ.gie && cpuRun && !holdQ;
    assign pwr.osc        = (stateQ != rswc_pkg::ST_SUSP);
    assign pwr.pll        = (stateQ != rswc_pkg::ST_SUSP);
    assign pwr.timer      = (stateQ != rswc_pkg::ST_SUSP);

    // =====================================================================
    // Assertions
    sequence s_wdrEntry;
        $rose(stateQ == rswc_pkg::ST_WDRST);
    endsequence

    property p_semi_abort;
        @(posedge clk) disable iff (sys_rst || porS2Q || !clkEn)
        (stateQ == rswc_pkg::ST_SEMI95) && busResetIn && !wdRoll
        |=> (stateQ == rswc_pkg::ST_RUN) && fetchZero;
    endproperty
    a_semi_abort: assert property (p_semi_abort)
        else $error("bus reset did not end start-up delay");

    property p_busrst_pend;
        @(posedge clk) disable iff (sys_rst || porS2Q || !clkEn)
        busResetIn && !wdRoll |=> ctlQ.busRst;
    endproperty
    a_busrst_pend: assert property (p_busrst_pend)
        else $error("bus reset flag not set");

    property p_wd_restart;
        @(posedge clk) disable iff (sys_rst || !clkEn)
        wdWr |=> (wdQ == '0);
    endproperty
    a_wd_restart: assert property (p_wd_restart)
        else $error("watchdog not cleared by restart write");

    property p_wd_roll;
        @(posedge clk) disable iff (sys_rst || porS2Q || !clkEn)
        wdRun && (wdQ == WW'(WATCH_CYC - 1)) |=> (stateQ == rswc_pkg::ST_WDRST);
    endproperty
    a_wd_roll: assert property (p_wd_roll)
        else $error("watchdog rollover did not reset");

    property p_wdr_image;
        @(posedge clk) disable iff (sys_rst || porS2Q || !clkEn)
        s_wdrEntry |-> (pscImg[6:5] == 2'b10) && (pscImg[3:0] == 4'h1)
                       && (ctlQ.por == $past(ctlQ.por));
    endproperty
    a_wdr_image: assert property (p_wdr_image)
        else $error("watchdog reset image wrong");

    property p_wdr_len;
        @(posedge clk) disable iff (sys_rst || porS2Q || !clkEn)
        (stateQ == rswc_pkg::ST_WDRST) && hit(cntQ, WDR_CYC)
        |=> (stateQ == rswc_pkg::ST_RUN) && fetchZero;
    endproperty
    a_wdr_len: assert property (p_wdr_len)
        else $error("watchdog reset length wrong");

    property p_usb_clear;
        @(posedge clk) disable iff (sys_rst)
        s_wdrEntry |-> usbAddrClear;
    endproperty
    a_usb_clear: assert property (p_usb_clear)
        else $error("usb address not cleared");

    property p_susp_off;
        @(posedge clk) disable iff (sys_rst || porS2Q || !clkEn)
        (stateQ == rswc_pkg::ST_SUSP) |-> (!pwr.osc && !pwr.pll) ##1 $stable(wdQ);
    endproperty
    a_susp_off: assert property (p_susp_off)
        else $error("clocks or watchdog run in suspend");

    property p_no_wake;
        @(posedge clk) disable iff (sys_rst || porS2Q || !clkEn)
        (stateQ == rswc_pkg::ST_SUSP) && !gpioWake && !anyAct
        |=> (stateQ == rswc_pkg::ST_SUSP);
    endproperty
    a_no_wake: assert property (p_no_wake)
        else $error("left suspend without cause");

    property p_wake_hold;
        @(posedge clk) disable iff (sys_rst || porS2Q || !clkEn)
        (stateQ == rswc_pkg::ST_WAKE) ##1 (stateQ == rswc_pkg::ST_RUN)
        |-> irqHold && !busResetIrqReq;
    endproperty
    a_wake_hold: assert property (p_wake_hold)
        else $error("interrupt served before first instruction");

    property p_halt;
        @(posedge clk) disable iff (sys_rst || porS2Q || !clkEn)
        (stateQ == rswc_pkg::ST_RUN) && cpu.halt && !wdRoll && !busResetIn
        |=> (pscImg[6:0] == 7'h00) && !cpuRun;
    endproperty
    a_halt: assert property (p_halt)
        else $error("halt did not clear register");

    property p_susp_ign;
        @(posedge clk) disable iff (sys_rst || porS2Q || !clkEn)
        pscWr && anyAct |=> (stateQ != rswc_pkg::ST_SUSP);
    endproperty
    a_susp_ign: assert property (p_susp_ign)
        else $error("suspend entered under activity");

endmodule

// ---- logic/rswc_map.svh ----
// Offsets, field positions, reset values and timing figures of the reset,
// suspend and watchdog controller.
// Assumes one inclusion per compile unit; guarded against repeats.
`ifndef RSWC_MAP_SVH
`define RSWC_MAP_SVH

// =====================================================================
// I/O addresses
`define RSWC_A_WD_RESTART 8'h26
`define RSWC_A_PSC        8'hff

// =====================================================================
// Status and control field positions
`define RSWC_B_RUN   0
`define RSWC_B_RSVD  1
`define RSWC_B_GIE   2
`define RSWC_B_SUSP  3
`define RSWC_B_POR   4
`define RSWC_B_BUSRST 5
`define RSWC_B_WDR   6
`define RSWC_B_IRQ   7

// =====================================================================
// Register images
`define RSWC_PSC_RST 8'h11
`define RSWC_PSC_WDR 8'h41

// =====================================================================
// Clock rate and times
`define RSWC_CLK_KHZ     20000
`define RSWC_T_SEMI1_US  1000
`define RSWC_T_SEMI95_US 95000
`define RSWC_T_WDR_US    2000
`define RSWC_T_WATCH_US  8000
`define RSWC_T_RESUME_US 1000

`endif

// ---- logic/rswc_pkg.sv ----
// Types shared by the reset, suspend and watchdog controller.
// Assumes nothing of its surroundings.
package rswc_pkg;

    typedef enum logic [2:0] {
        ST_POR    = 3'b000,
        ST_SEMI1  = 3'b001,
        ST_SEMI95 = 3'b010,
        ST_RUN    = 3'b011,
        ST_WDRST  = 3'b100,
        ST_HALT   = 3'b101,
        ST_SUSP   = 3'b110,
        ST_WAKE   = 3'b111
    } rswc_state_e;

    typedef struct packed {
        logic watchdog_reset_event;
        logic busRst;
        logic por;
        logic gie;
        logic rsvd;
        logic run;
    } rswc_ctl_s;

    typedef struct packed {
        logic halt;
        logic ei;
        logic di;
        logic interrupt_return_instruction;
        logic ack;
        logic done;
    } rswc_cpu_s;

    typedef struct packed {
        logic osc;
        logic pll;
        logic timer;
    } rswc_pwr_s;

endpackage

// ---- testbench/rswc_host_model.sv ----
// Upstream host model: bus reset pulses and non-idle activity on the upstream port.
// Assumes clk is the controller clock; the bench calls its tasks.
`timescale 1ns/100ps

module rswc_host_model (
    // Clock
    input  wire logic clk,
    // Upstream bus events
    output logic      busResetIn,
    output logic      upActivity
);
    initial begin
        busResetIn = 1'b0;
        upActivity = 1'b0;
    end

    // =====================================================================
    // Bus signalling
    // Bus reset pulse
    task automatic bus_reset();
        @(posedge clk);
        busResetIn <= 1'b1;
        @(posedge clk);
        busResetIn <= 1'b0;
    endtask

    task automatic set_activity(input logic v);
        @(posedge clk);
        upActivity <= v;
    endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the reset, suspend and watchdog controller.
// Assumes short timing parameters; the host model drives the upstream events.
`timescale 1ns/100ps

`define CHK(nm, exp, got) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
    end \
end

module testbench;
    logic                clk;
    logic                sys_rst;
    logic                clkEn;
    logic                porIn;
    logic                oscStable;
    logic                busResetIn;
    logic                upActivity;
    logic [3:0]          downActivity;
    logic                gpioWake;
    logic                busResetIntEn;
    logic                irqPendingIn;
    rswc_pkg::rswc_cpu_s cpu;
    logic [7:0]          ioAddr;
    logic [7:0]          ioWrData;
    logic                ioWr;
    logic                ioRd;
    logic [7:0]          ioRdData;
    logic                cpuReset;
    logic                cpuRun;
    logic                fetchZero;
    logic                usbAddrClear;
    logic                irqHold;
    logic                busResetIrqReq;
    rswc_pkg::rswc_pwr_s pwr;
    int                  err_count;
    int                  comparisons;
    int                  n;

    rswc_ctrl #(.SEMI1_CYC(8), .SEMI95_CYC(20), .WDR_CYC(10), .WATCH_CYC(200),
                .RESUME_CYC(6)) i_rswc_ctrl (
        .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .porIn(porIn),
        .oscStable(oscStable), .busResetIn(busResetIn), .upActivity(upActivity),
        .downActivity(downActivity), .gpioWake(gpioWake), .busResetIntEn(busResetIntEn),
        .irqPendingIn(irqPendingIn), .cpu(cpu), .ioAddr(ioAddr), .ioWrData(ioWrData),
        .ioWr(ioWr), .ioRd(ioRd), .ioRdData(ioRdData), .cpuReset(cpuReset),
        .cpuRun(cpuRun), .fetchZero(fetchZero), .usbAddrClear(usbAddrClear),
        .irqHold(irqHold), .busResetIrqReq(busResetIrqReq), .pwr(pwr));

    rswc_host_model i_rswc_host_model (
        .clk(clk), .busResetIn(busResetIn), .upActivity(upActivity));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // =====================================================================
    // Access tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        ioAddr <= a;
        ioWrData <= d;
        ioWr <= 1'b1;
        @(posedge clk);
        ioWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] exp, input string nm);
        @(posedge clk);
        ioAddr <= 8'hff;
        ioRd <= 1'b1;
        @(posedge clk);
        ioRd <= 1'b0;
        #1;
        `CHK(nm, exp, ioRdData)
    endtask

    task automatic ins(input logic [5:0] v);
        @(posedge clk);
        cpu <= rswc_pkg::rswc_cpu_s'(v);
        @(posedge clk);
        cpu <= rswc_pkg::rswc_cpu_s'(6'h00);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    function automatic logic probe(input int s);
        case (s)
            0: return fetchZero === 1'b1;
            1: return cpuReset === 1'b1;
            default: return cpuRun === 1'b1;
        endcase
    endfunction

    // Bounded wait: 0 fetch pulse, 1 core reset, 2 core running
    task automatic wait_on(input int s, output int k);
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (!probe(s) && k < 1000);
        if (k >= 1000) begin
            err_count++;
            $display("ERROR wait %0d expected event seen timeout", s);
            wrap_up();
        end
    endtask

    task automatic do_reset();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // =====================================================================
    // Main sequence
    initial begin
        err_count = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        clkEn = 1'b1;
        porIn = 1'b0;
        oscStable = 1'b1;
        downActivity = 4'h0;
        gpioWake = 1'b0;
        busResetIntEn = 1'b0;
        irqPendingIn = 1'b0;
        cpu = rswc_pkg::rswc_cpu_s'(6'h00);
        ioAddr = 8'h00;
        ioWrData = 8'h00;
        ioWr = 1'b0;
        ioRd = 1'b0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        cyc(5);
        i_rswc_host_model.bus_reset();
        wait_on(0, n);
        `CHK("startup_len", 1'b1, (n + 7 >= 28 && n + 7 <= 38))
        rd(8'h31, "status_por");
        $display("test startup done");

        wr(8'h26, 8'h00);
        @(posedge clk);
        irqPendingIn <= 1'b1;
        wr(8'hff, 8'h05);
        rd(8'h81, "gie_write");
        ins(6'h10);
        rd(8'h85, "gie_ei");
        ins(6'h08);
        rd(8'h81, "gie_di");
        @(posedge clk);
        irqPendingIn <= 1'b0;
        $display("test status done");

        i_rswc_host_model.set_activity(1'b1);
        wr(8'hff, 8'h09);
        cyc(3);
        `CHK("susp_refused", 3'h7, pwr)
        i_rswc_host_model.set_activity(1'b0);
        for (int s = 0; s < 3; s++) begin
            wr(8'h26, 8'h00);
            wr(8'hff, 8'h09);
            cyc(10);
            `CHK("susp_pwr", 3'h0, pwr)
            `CHK("susp_run", 1'b0, cpuRun)
            if (s == 1) begin
                i_rswc_host_model.set_activity(1'b1);
            end else begin
                @(posedge clk);
                gpioWake <= (s == 0);
                downActivity <= {1'b0, (s == 2), 2'b00};
            end
            wait_on(2, n);
            `CHK("resume_len", 1'b1, (n >= 6 && n <= 14))
            `CHK("wake_hold", 1'b1, irqHold)
            @(posedge clk);
            gpioWake <= 1'b0;
            downActivity <= 4'h0;
            i_rswc_host_model.set_activity(1'b0);
            ins(6'h01);
            cyc(1);
            `CHK("hold_free", 1'b0, irqHold)
            rd(8'h01, "wake_status");
        end
        $display("test suspend done");

        wr(8'h26, 8'h00);
        ins(6'h20);
        rd(8'h00, "halt_status");
        `CHK("halt_run", 1'b0, cpuRun)
        wait_on(1, n);
        `CHK("wdr_usb", 1'b1, usbAddrClear)
        wait_on(0, n);
        `CHK("wdr_len", 1'b1, (n >= 9 && n <= 12))
        rd(8'h41, "wdr_status");
        `CHK("cause_wdr", 1'b1, (ioRdData[6] && !ioRdData[4]))
        wait_on(1, n);
        `CHK("wdr_restart", 1'b1, (n >= 194 && n <= 202))
        wait_on(0, n);
        repeat (3) begin
            cyc(150);
            wr(8'h26, 8'h5a);
        end
        `CHK("kick_hold", 1'b0, cpuReset)
        wait_on(1, n);
        `CHK("watch_len", 1'b1, (n >= 196 && n <= 202))
        $display("test watchdog done");

        do_reset();
        cyc(18);
        i_rswc_host_model.bus_reset();
        cyc(0);
        `CHK("abort_len", 1'b1, fetchZero)
        cyc(1);
        `CHK("abort_run", 1'b1, cpuRun)
        `CHK("irq_masked", 1'b0, busResetIrqReq)
        @(posedge clk);
        busResetIntEn <= 1'b1;
        cyc(2);
        `CHK("irq_no_gie", 1'b0, busResetIrqReq)
        ins(6'h10);
        cyc(1);
        `CHK("irq_req", 1'b1, busResetIrqReq)
        rd(8'h35, "abort_status");
        $display("test abort done");

        @(posedge clk);
        porIn <= 1'b1;
        oscStable <= 1'b0;
        cyc(4);
        porIn <= 1'b0;
        cyc(10);
        `CHK("osc_wait", 1'b1, cpuReset)
        @(posedge clk);
        oscStable <= 1'b1;
        wait_on(0, n);
        rd(8'h11, "por_status");
        @(posedge clk);
        clkEn <= 1'b0;
        cyc(300);
        `CHK("freeze_wd", 1'b0, cpuReset)
        @(posedge clk);
        clkEn <= 1'b1;
        cyc(2);
        `CHK("freeze_run", 1'b1, cpuRun)
        $display("test por done");
        wrap_up();
    end
endmodule
